// [verilog/dprp_regs.sv]
// Purpose: Second/third reference profile registers of the first digital loop
// Assumes: Host port on sys_clk; strobes one cycle long, never both at once
// Notes:   Read data valid only in the cycle after the read strobe
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1 - Second reference selection level in bits 2:1, 0 highest, resets to 00.
// RULE2 - Second reference bit 0 permits loop lock; zero at reset blocks it.
// RULE3 - Third reference control byte at 0x045a, same layout, resets zero.
// RULE4 - Bandwidth scale 17 bits, 0.1 Hz units, low two bytes plus bit 0.
// RULE5 - Software must program a nonzero bandwidth scale before using the loop.
// RULE6 - Software keeps bandwidth below phase detector frequency divided by 20.
// RULE7 - Software avoids bandwidths under 50 Hz with crystal system clock.
// RULE8 - Bit 1 of third bandwidth byte selects high phase margin filter.
// RULE9 - High margin filter peaking small to 2 kHz; advised above too.
// RULE10 - Integer divider 18 bits holding value minus one, resets zero.
// RULE11 - Fractional numerator 24 bits, three bytes, low byte first, resets zero.
// RULE12 - Fractional modulus 24 bits, three bytes, low byte first, resets zero.
// RULE13 - Bandwidth field and its reserved bits read zero after reset.
// RULE14 - Zero modulus disables and bypasses the fractional divider.
// RULE15 - Ratio is integer field plus one, plus numerator over nonzero modulus.
// RULE16 - Multi-byte fields assembled whole; reserved bits ignore writes, read zero. Here each byte write updates its field at once.
module dprp_regs (
	input wire logic sys_clk, // System clock, 20 MHz
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic [dprp_pkg::ADDR_W-1:0] reg_addr, // Register byte address
	input wire logic [dprp_pkg::BYTE_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [dprp_pkg::BYTE_W-1:0] reg_rdata, // Read data, cycle after strobe
	output logic [dprp_pkg::PRIO_W-1:0] second_ref_selection_level, // 0 highest
	output logic second_ref_lock_permit, // Loop may lock to second reference
	output logic [dprp_pkg::BW_W-1:0] second_ref_bw_scale, // Bandwidth, 0.1 Hz units
	output logic second_ref_high_pm_filter, // High phase margin filter chosen
	output logic second_ref_bw_nonzero, // Bandwidth scale programmed
	output logic [dprp_pkg::NDIV_W-1:0] integer_feedback_divider, // Divide value minus one
	output logic [dprp_pkg::RATIO_W-1:0] feedback_int_ratio, // Integer part of ratio
	output logic [dprp_pkg::FRAC_W-1:0] fractional_numerator, // Fraction numerator
	output logic [dprp_pkg::FRAC_W-1:0] fractional_modulus, // Fraction denominator
	output logic fractional_active, // Fractional divider in use
	output logic [dprp_pkg::PRIO_W-1:0] third_ref_selection_level, // 0 highest
	output logic third_ref_lock_permit // Loop may lock to third reference
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	dprp_pkg::dprp_state_s s_q;
	dprp_pkg::dprp_state_s s_d;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rd_data = dprp_pkg::RST_BYTE;
		if (reg_wr) begin
			case (reg_addr)
				dprp_pkg::OFS_B_PRIO_EN: begin
					s_d.b_level = reg_wdata[dprp_pkg::PRIO_LSB +: dprp_pkg::PRIO_W]; // see RULE1
					s_d.b_permit = reg_wdata[dprp_pkg::EN_BIT]; // see RULE2
				end
				dprp_pkg::OFS_B_BW_LOW: begin
					s_d.b_bw[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE4
				end
				dprp_pkg::OFS_B_BW_MID: begin
					s_d.b_bw[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE4
				end
				dprp_pkg::OFS_B_BW_TOP_FILT: begin
					s_d.b_bw[dprp_pkg::LANE2] = reg_wdata[dprp_pkg::BW_TOP_BIT]; // see RULE4
					s_d.b_high_pm = reg_wdata[dprp_pkg::FILT_BIT]; // see RULE8
				end
				dprp_pkg::OFS_B_NDIV_LOW: begin
					s_d.b_ndiv[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE10
				end
				dprp_pkg::OFS_B_NDIV_MID: begin
					s_d.b_ndiv[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE10
				end
				dprp_pkg::OFS_B_NDIV_HIGH: begin
					// Upper six bits are reserved and dropped
					s_d.b_ndiv[dprp_pkg::LANE2 +: dprp_pkg::NDIV_TOP_W] =
						reg_wdata[dprp_pkg::LANE0 +: dprp_pkg::NDIV_TOP_W]; // see RULE10, see RULE16
				end
				dprp_pkg::OFS_B_FNUM_LOW: begin
					s_d.b_fnum[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE11
				end
				dprp_pkg::OFS_B_FNUM_MID: begin
					s_d.b_fnum[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE11
				end
				dprp_pkg::OFS_B_FNUM_HIGH: begin
					s_d.b_fnum[dprp_pkg::LANE2 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE11
				end
				dprp_pkg::OFS_B_FMOD_LOW: begin
					s_d.b_fmod[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE12
				end
				dprp_pkg::OFS_B_FMOD_MID: begin
					s_d.b_fmod[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE12
				end
				dprp_pkg::OFS_B_FMOD_HIGH: begin
					s_d.b_fmod[dprp_pkg::LANE2 +: dprp_pkg::BYTE_W] = reg_wdata; // see RULE12
				end
				dprp_pkg::OFS_C_PRIO_EN: begin
					s_d.c_level = reg_wdata[dprp_pkg::PRIO_LSB +: dprp_pkg::PRIO_W]; // see RULE3
					s_d.c_permit = reg_wdata[dprp_pkg::EN_BIT]; // see RULE3
				end
				default: begin
					// Unmapped writes are dropped
					s_d.rd_data = dprp_pkg::RST_BYTE;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				dprp_pkg::OFS_B_PRIO_EN: begin
					s_d.rd_data = {{(dprp_pkg::BYTE_W-dprp_pkg::PRIO_W-1){1'b0}},
						s_q.b_level, s_q.b_permit}; // see RULE16
				end
				dprp_pkg::OFS_B_BW_LOW: begin
					s_d.rd_data = s_q.b_bw[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_BW_MID: begin
					s_d.rd_data = s_q.b_bw[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_BW_TOP_FILT: begin
					s_d.rd_data = {{(dprp_pkg::BYTE_W-dprp_pkg::FILT_BIT-1){1'b0}},
						s_q.b_high_pm, s_q.b_bw[dprp_pkg::LANE2]}; // see RULE13
				end
				dprp_pkg::OFS_B_NDIV_LOW: begin
					s_d.rd_data = s_q.b_ndiv[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_NDIV_MID: begin
					s_d.rd_data = s_q.b_ndiv[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_NDIV_HIGH: begin
					s_d.rd_data = {{(dprp_pkg::BYTE_W-dprp_pkg::NDIV_TOP_W){1'b0}},
						s_q.b_ndiv[dprp_pkg::LANE2 +: dprp_pkg::NDIV_TOP_W]}; // see RULE16
				end
				dprp_pkg::OFS_B_FNUM_LOW: begin
					s_d.rd_data = s_q.b_fnum[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_FNUM_MID: begin
					s_d.rd_data = s_q.b_fnum[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_FNUM_HIGH: begin
					s_d.rd_data = s_q.b_fnum[dprp_pkg::LANE2 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_FMOD_LOW: begin
					s_d.rd_data = s_q.b_fmod[dprp_pkg::LANE0 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_FMOD_MID: begin
					s_d.rd_data = s_q.b_fmod[dprp_pkg::LANE1 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_B_FMOD_HIGH: begin
					s_d.rd_data = s_q.b_fmod[dprp_pkg::LANE2 +: dprp_pkg::BYTE_W];
				end
				dprp_pkg::OFS_C_PRIO_EN: begin
					s_d.rd_data = {{(dprp_pkg::BYTE_W-dprp_pkg::PRIO_W-1){1'b0}},
						s_q.c_level, s_q.c_permit}; // see RULE3
				end
				default: begin
					s_d.rd_data = dprp_pkg::RST_BYTE;
				end
			endcase
		end
		// Derived views track the stored fields in the same cycle
		s_d.frac_on = (s_d.b_fmod != dprp_pkg::RST_FRAC); // see RULE14
		s_d.bw_nonzero = (s_d.b_bw != dprp_pkg::RST_BW); // see RULE5
		s_d.int_ratio = {1'b0, s_d.b_ndiv} + dprp_pkg::RATIO_ONE; // see RULE15
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			s_q.b_level <= dprp_pkg::RST_PRIO; // see RULE1
			s_q.b_permit <= dprp_pkg::RST_EN; // see RULE2
			s_q.b_bw <= dprp_pkg::RST_BW; // see RULE13
			s_q.b_high_pm <= dprp_pkg::RST_FILT; // see RULE8
			s_q.b_ndiv <= dprp_pkg::RST_NDIV; // see RULE10
			s_q.b_fnum <= dprp_pkg::RST_FRAC; // see RULE11
			s_q.b_fmod <= dprp_pkg::RST_FRAC; // see RULE12
			s_q.c_level <= dprp_pkg::RST_PRIO; // see RULE3
			s_q.c_permit <= dprp_pkg::RST_EN;
			s_q.rd_data <= dprp_pkg::RST_BYTE;
			s_q.frac_on <= 1'b0;
			s_q.bw_nonzero <= 1'b0;
			s_q.int_ratio <= dprp_pkg::RST_RATIO;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------
	// Outputs, all straight from state flops
	// ----------------------------------------
	assign reg_rdata = s_q.rd_data;
	assign second_ref_selection_level = s_q.b_level;
	assign second_ref_lock_permit = s_q.b_permit;
	assign second_ref_bw_scale = s_q.b_bw;
	assign second_ref_high_pm_filter = s_q.b_high_pm;
	assign second_ref_bw_nonzero = s_q.bw_nonzero;
	assign integer_feedback_divider = s_q.b_ndiv;
	assign feedback_int_ratio = s_q.int_ratio;
	assign fractional_numerator = s_q.b_fnum;
	// Numerator is passed as stored; consumers must gate it with fractional_active
	assign fractional_modulus = s_q.b_fmod;
	assign fractional_active = s_q.frac_on; // see RULE14
	assign third_ref_selection_level = s_q.c_level;
	assign third_ref_lock_permit = s_q.c_permit;
endmodule : dprp_regs

`default_nettype wire

// [pkg/dprp_pkg.sv]
// Purpose: Constants and state layout for the reference profile register bank
// Assumes: 16-bit byte addresses, 8-bit register data
// Notes:   All registers reset to zero except the integer ratio, which resets to one
package dprp_pkg;
	// ----------------------------------------
	// Bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam int BYTE_W = 8;
	localparam int LANE0 = 0;
	localparam int LANE1 = 8;
	localparam int LANE2 = 16;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [ADDR_W-1:0] OFS_B_PRIO_EN = 16'h044d;
	localparam logic [ADDR_W-1:0] OFS_B_BW_LOW = 16'h044e;
	localparam logic [ADDR_W-1:0] OFS_B_BW_MID = 16'h044f;
	localparam logic [ADDR_W-1:0] OFS_B_BW_TOP_FILT = 16'h0450;
	localparam logic [ADDR_W-1:0] OFS_B_NDIV_LOW = 16'h0451;
	localparam logic [ADDR_W-1:0] OFS_B_NDIV_MID = 16'h0452;
	localparam logic [ADDR_W-1:0] OFS_B_NDIV_HIGH = 16'h0453;
	localparam logic [ADDR_W-1:0] OFS_B_FNUM_LOW = 16'h0454;
	localparam logic [ADDR_W-1:0] OFS_B_FNUM_MID = 16'h0455;
	localparam logic [ADDR_W-1:0] OFS_B_FNUM_HIGH = 16'h0456;
	localparam logic [ADDR_W-1:0] OFS_B_FMOD_LOW = 16'h0457;
	localparam logic [ADDR_W-1:0] OFS_B_FMOD_MID = 16'h0458;
	localparam logic [ADDR_W-1:0] OFS_B_FMOD_HIGH = 16'h0459;
	localparam logic [ADDR_W-1:0] OFS_C_PRIO_EN = 16'h045a;

	// ----------------------------------------
	// Field widths and positions
	// ----------------------------------------
	localparam int PRIO_W = 2;
	localparam int PRIO_LSB = 1;
	localparam int EN_BIT = 0;
	localparam int BW_W = 17;
	localparam int BW_TOP_BIT = 0;
	localparam int FILT_BIT = 1;
	localparam int NDIV_W = 18;
	localparam int NDIV_TOP_W = 2;
	localparam int FRAC_W = 24;
	localparam int RATIO_W = NDIV_W + 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [PRIO_W-1:0] RST_PRIO = 2'h0;
	localparam logic RST_EN = 1'h0;
	localparam logic [BW_W-1:0] RST_BW = 17'h00000;
	localparam logic RST_FILT = 1'h0;
	localparam logic [NDIV_W-1:0] RST_NDIV = 18'h00000;
	localparam logic [FRAC_W-1:0] RST_FRAC = 24'h000000;
	localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
	localparam logic [RATIO_W-1:0] RST_RATIO = 19'h00001;
	localparam logic [RATIO_W-1:0] RATIO_ONE = 19'h00001;

	// ----------------------------------------
	// State of the bank
	// ----------------------------------------
	typedef struct packed {
		logic [PRIO_W-1:0] b_level;
		logic b_permit;
		logic [BW_W-1:0] b_bw;
		logic b_high_pm;
		logic [NDIV_W-1:0] b_ndiv;
		logic [FRAC_W-1:0] b_fnum;
		logic [FRAC_W-1:0] b_fmod;
		logic [PRIO_W-1:0] c_level;
		logic c_permit;
		logic [BYTE_W-1:0] rd_data;
		logic frac_on;
		logic bw_nonzero;
		logic [RATIO_W-1:0] int_ratio;
	} dprp_state_s;
endpackage : dprp_pkg

// [testbench/dprp_regs_chk.sv]
// Purpose: Port-level checks on the reference profile register bank
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module dprp_chk (
	input wire logic sys_clk, // Bank clock
	input wire logic nrst, // Async reset, active low
	input wire logic [dprp_pkg::ADDR_W-1:0] reg_addr, // Byte address
	input wire logic [dprp_pkg::BYTE_W-1:0] reg_wdata, // Write data
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	input wire logic [dprp_pkg::BYTE_W-1:0] reg_rdata, // Read data
	input wire logic [dprp_pkg::PRIO_W-1:0] second_ref_selection_level, // Level
	input wire logic second_ref_lock_permit, // Permit
	input wire logic [dprp_pkg::BW_W-1:0] second_ref_bw_scale, // Bandwidth
	input wire logic second_ref_high_pm_filter, // Filter choice
	input wire logic second_ref_bw_nonzero, // Bandwidth set
	input wire logic [dprp_pkg::NDIV_W-1:0] integer_feedback_divider, // Divider
	input wire logic [dprp_pkg::RATIO_W-1:0] feedback_int_ratio, // Ratio
	input wire logic [dprp_pkg::FRAC_W-1:0] fractional_modulus, // Modulus
	input wire logic fractional_active, // Fraction in use
	input wire logic [dprp_pkg::PRIO_W-1:0] third_ref_selection_level, // Level
	input wire logic third_ref_lock_permit // Permit
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence b_wr(a);
		reg_wr && reg_addr == a;
	endsequence
	sequence prio_rd;
		reg_rd && reg_addr == dprp_pkg::OFS_B_PRIO_EN;
	endsequence
	a_b_prio_write: assert property (b_wr(dprp_pkg::OFS_B_PRIO_EN) |=>
		{second_ref_selection_level, second_ref_lock_permit} == $past(reg_wdata[2:0])) else $error("prio write");
	a_c_prio_write: assert property (b_wr(dprp_pkg::OFS_C_PRIO_EN) |=>
		{third_ref_selection_level, third_ref_lock_permit} == $past(reg_wdata[2:0])) else $error("third write");
	a_filt_top_write: assert property (b_wr(dprp_pkg::OFS_B_BW_TOP_FILT) |=>
		{second_ref_high_pm_filter, second_ref_bw_scale[16]} == $past(reg_wdata[1:0])) else $error("filter write");
	a_ndiv_high_write: assert property (b_wr(dprp_pkg::OFS_B_NDIV_HIGH) |=> integer_feedback_divider ==
		{$past(reg_wdata[1:0]), $past(integer_feedback_divider[15:0])}) else $error("divider top write");
	a_ratio_plus_one: assert property (feedback_int_ratio == integer_feedback_divider + 19'h00001)
		else $error("ratio not field plus one");
	a_frac_bypass: assert property (fractional_active == (fractional_modulus != 24'h000000))
		else $error("fraction active wrong");
	a_bw_status: assert property (second_ref_bw_nonzero == (second_ref_bw_scale != 17'h00000))
		else $error("bandwidth status wrong");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
	a_prio_readback: assert property (prio_rd |=> reg_rdata ==
		{5'h00, $past(second_ref_selection_level), $past(second_ref_lock_permit)}) else $error("prio read");
endmodule : dprp_chk
bind dprp_regs dprp_chk chk_u (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.second_ref_selection_level, .second_ref_lock_permit, .second_ref_bw_scale, .second_ref_high_pm_filter,
	.second_ref_bw_nonzero, .integer_feedback_divider, .feedback_int_ratio, .fractional_modulus,
	.fractional_active, .third_ref_selection_level, .third_ref_lock_permit);
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Register-level test of the reference profile bank
// Assumes: 20 MHz clock, strobes driven by non-blocking assignment
// Notes:   Read data is sampled in the single cycle it stands
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic sys_clk, nrst, reg_wr, reg_rd, second_ref_lock_permit, second_ref_high_pm_filter;
	logic second_ref_bw_nonzero, fractional_active, third_ref_lock_permit;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] second_ref_selection_level, third_ref_selection_level;
	logic [16:0] second_ref_bw_scale;
	logic [17:0] integer_feedback_divider;
	logic [18:0] feedback_int_ratio;
	logic [23:0] fractional_numerator, fractional_modulus;
	int error_cnt = 0;
	int num_checks = 0;
	dprp_regs dut_u (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.second_ref_selection_level, .second_ref_lock_permit, .second_ref_bw_scale, .second_ref_high_pm_filter,
		.second_ref_bw_nonzero, .integer_feedback_divider, .feedback_int_ratio, .fractional_numerator,
		.fractional_modulus, .fractional_active, .third_ref_selection_level, .third_ref_lock_permit);
	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp, "reg_rdata");
	endtask : rd
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		nrst = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 14; i++)
			rd(16'(16'h044d + i), 8'h00);
		chk(feedback_int_ratio, 24'h000001, "ratio");
		for (int i = 0; i < 4; i++) begin
			wr(16'h044d, 8'(i * 2 + 1));
			chk(second_ref_selection_level, 24'(i), "level");
			chk(second_ref_lock_permit, 24'h000001, "permit");
			rd(16'h044d, 8'(i * 2 + 1));
		end
		wr(16'h044d, 8'hf8);
		chk(second_ref_lock_permit, 24'h000000, "permit");
		rd(16'h044d, 8'h00);
		wr(16'h045a, 8'hfd);
		chk({third_ref_selection_level, third_ref_lock_permit}, 24'h000005, "third");
		rd(16'h045a, 8'h05);
		// 0x11234 is about 7 kHz: assumes a phase detector well above 20 times that
		wr(16'h044e, 8'h34);
		wr(16'h044f, 8'h12);
		chk(second_ref_bw_nonzero, 24'h000001, "bw status");
		wr(16'h0450, 8'hff);
		chk(second_ref_bw_scale, 24'h011234, "bw");
		chk(second_ref_high_pm_filter, 24'h000001, "filter");
		rd(16'h0450, 8'h03);
		// Drop to about 466 Hz and leave the high margin filter in the same write
		wr(16'h0450, 8'h00);
		chk(second_ref_high_pm_filter, 24'h000000, "filter");
		chk(second_ref_bw_scale, 24'h001234, "bw");
		wr(16'h0451, 8'hff);
		wr(16'h0452, 8'hff);
		wr(16'h0453, 8'hfe);
		chk(integer_feedback_divider, 24'h02ffff, "divider");
		chk(feedback_int_ratio, 24'h030000, "ratio");
		rd(16'h0453, 8'h02);
		wr(16'h0454, 8'h12);
		wr(16'h0455, 8'h34);
		wr(16'h0456, 8'h56);
		chk(fractional_numerator, 24'h563412, "numerator");
		rd(16'h0456, 8'h56);
		chk(fractional_active, 24'h000000, "frac on");
		wr(16'h0459, 8'h80);
		chk(fractional_active, 24'h000001, "frac on");
		wr(16'h0457, 8'hef);
		wr(16'h0458, 8'hcd);
		chk(fractional_modulus, 24'h80cdef, "modulus");
		rd(16'h0458, 8'hcd);
		wr(16'h0459, 8'h00);
		wr(16'h0458, 8'h00);
		chk(fractional_active, 24'h000001, "frac on");
		wr(16'h0457, 8'h00);
		chk(fractional_active, 24'h000000, "frac on");
		wr(16'h045b, 8'hff);
		rd(16'h045b, 8'h00);
		rd(16'h044c, 8'h00);
		chk(third_ref_selection_level, 24'h000002, "third level");
		// Mid-run reset must clear the checked fields again and return the ratio to one
		@(posedge sys_clk);
		nrst <= 1'b0;
		@(posedge sys_clk);
		nrst <= 1'b1;
		rd(16'h0450, 8'h00);
		chk(feedback_int_ratio, 24'h000001, "ratio");
		chk(second_ref_bw_nonzero, 24'h000000, "bw status");
		chk(third_ref_selection_level, 24'h000000, "third level");
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
